// File: hdl/ast_pkg.sv
// Purpose: Shared constants and types of the async serial transceiver
// Assumes: One core clock; all timing is counted in 16x bit ticks
// Notes:   Sample points, shared reset values and counts live here
package ast_pkg;

  // Oversampling: ticks per bit and the three central sample points
  localparam int          TICKS_PER_BIT = 16;
  localparam logic [3:0]  TICK_LAST     = 4'hf;
  localparam logic [3:0]  SAMPLE_FIRST  = 4'h7;
  localparam logic [3:0]  SAMPLE_MID    = 4'h8;
  localparam logic [3:0]  SAMPLE_LAST   = 4'h9;

  // Frame lengths in bits: start + data + stop, and the one-bit mark after a break
  localparam logic [3:0]  FRAME_BITS_8  = 4'ha;
  localparam logic [3:0]  FRAME_BITS_9  = 4'hb;
  localparam logic [3:0]  MARK_BITS     = 4'h1;

  // Idle line: a whole frame of ticks at line high
  localparam logic [7:0]  IDLE_TICKS_8  = 8'ha0;
  localparam logic [7:0]  IDLE_TICKS_9  = 8'hb0;

  // Rate divider: with a zero extended value, 16x tick period is 2*shared*2^factor cycles
  localparam int          DIV_WIDTH     = 12;
  localparam logic [11:0] CONV_MULT     = 12'h002;
  localparam logic [11:0] PRESCALE_A    = 12'h001;
  localparam logic [11:0] PRESCALE_B    = 12'h003;
  localparam logic [11:0] PRESCALE_C    = 12'h004;
  localparam logic [11:0] PRESCALE_D    = 12'h00d;

  // Values after reset
  localparam logic        TX_EMPTY_RST  = 1'b1;
  localparam logic        TX_DONE_RST   = 1'b1;
  localparam logic        IDLE_ARM_RST  = 1'b1;
  localparam logic [7:0]  BYTE_RST      = 8'h00;

  // Transmit engine and receiver states
  typedef enum logic [1:0] {TX_WAIT, TX_SHIFT} ast_tx_state_type;
  typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_FRAME} ast_rx_state_type;

endpackage

// File: hdl/ast_transceiver.sv
// Purpose: Full-duplex asynchronous serial transmitter and receiver
// Assumes: Software strobes are one-cycle pulses on the core clock
// Notes:   Baud settings are only changed with both directions disabled
`timescale 1ns/100ps

module ast_transceiver
  import ast_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  // Software access strobes
  input  wire logic       STATUS_READ,
  input  wire logic       DATA_WRITE,
  input  wire logic [7:0] DATA_WRITE_VALUE,
  input  wire logic       DATA_READ,
  // Control bits
  input  wire logic       WORD_LEN_SEL,
  input  wire logic       TX_BIT8,
  input  wire logic       WAKE_METHOD,
  input  wire logic       TX_ENABLE,
  input  wire logic       RX_ENABLE,
  input  wire logic       SEND_BREAK,
  input  wire logic       RX_MUTE_SET,
  input  wire logic       RX_MUTE_CLEAR,
  input  wire logic       TX_EMPTY_IRQ_EN,
  input  wire logic       TX_COMPLETE_IRQ_EN,
  input  wire logic       RX_IRQ_EN,
  input  wire logic       IDLE_IRQ_EN,
  input  wire logic       GLOBAL_IRQ_MASK,
  // Rate settings
  input  wire logic [1:0] SHARED_PRESCALE,
  input  wire logic [2:0] TX_DIVIDE_FACTOR,
  input  wire logic [2:0] RX_DIVIDE_FACTOR,
  input  wire logic [7:0] EXT_TX_PRESCALE,
  input  wire logic [7:0] EXT_RX_PRESCALE,
  // Serial pins
  input  wire logic       SERIAL_IN_PIN,
  output logic            SERIAL_OUT_PIN,
  output logic            SERIAL_OUT_EN,
  // Status and received data
  output logic            TX_EMPTY_FLAG,
  output logic            TX_COMPLETE_FLAG,
  output logic            RX_FULL_FLAG,
  output logic            IDLE_FLAG,
  output logic            OVERRUN_FLAG,
  output logic            NOISE_FLAG,
  output logic            FRAMING_ERROR_FLAG,
  output logic            RX_MUTE_BIT,
  output logic [7:0]      RX_DATA,
  output logic            RX_BIT8,
  output logic            IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Rate generators, index 0 transmit, index 1 receive

  logic [1:0]           tick;          // 16x bit-rate strobes
  logic [11:0]          shared_val;    // Shared prescale value
  logic [2:0]           factor_sel [2];
  logic [7:0]           ext_val    [2];

  assign factor_sel[0] = TX_DIVIDE_FACTOR;
  assign factor_sel[1] = RX_DIVIDE_FACTOR;
  assign ext_val[0]    = EXT_TX_PRESCALE;
  assign ext_val[1]    = EXT_RX_PRESCALE;

  // Shared prescale decode
  always_comb begin
    case (SHARED_PRESCALE)
      2'h0:    shared_val = PRESCALE_A;
      2'h1:    shared_val = PRESCALE_B;
      2'h2:    shared_val = PRESCALE_C;
      default: shared_val = PRESCALE_D;
    endcase
  end

  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_rate
      logic [11:0] period;             // Cycles per 16x tick
      logic [11:0] count_reg;          // Cycle counter

      // Extended path wins when its value is nonzero
      assign period = (ext_val[d] != 8'h00)
                    ? {4'h0, ext_val[d]}
                    : (CONV_MULT * shared_val) << factor_sel[d];

      // Free-running divider; settings assumed stable while enabled
      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          count_reg <= 12'h000;
        end else if (count_reg + 12'h001 >= period) begin
          count_reg <= 12'h000;
        end else begin
          count_reg <= count_reg + 12'h001;
        end
      end

      assign tick[d] = (count_reg + 12'h001 >= period);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  ast_tx_state_type tx_state_reg;      // Idle or shifting
  logic [10:0]      tx_shift_reg;      // Frame bits, LSB goes first
  logic [3:0]       tx_bits_reg;       // Bits left in frame
  logic [3:0]       tx_sub_reg;        // Tick within bit
  logic [7:0]       tx_buffer_reg;     // Waiting word
  logic             tx_buf8_reg;       // Its ninth bit
  logic             te_prev_reg;       // Enable one cycle ago
  logic             preamble_reg;      // Idle frame owed
  logic             after_break_reg;   // Last frame was a break
  logic             tx_arm_reg;        // Status read seen
  logic [3:0]       frame_len;         // Bits per frame now
  logic             start_go;          // Load a frame this cycle
  logic [10:0]      start_pat;         // Pattern to load
  logic [3:0]       start_len;         // Its length
  logic             take_buf;          // Buffer moves to shifter
  logic             wr_direct;         // Write starts a frame
  logic             frame_end;         // Last tick of a frame
  logic             start_break;       // Break frame chosen
  logic             tx_clear;          // Armed data write

  assign frame_len = WORD_LEN_SEL ? FRAME_BITS_9 : FRAME_BITS_8;
  assign frame_end = (tx_state_reg == TX_SHIFT) && tick[0]
                   && (tx_sub_reg == TICK_LAST) && (tx_bits_reg == MARK_BITS);
  assign tx_clear  = DATA_WRITE && tx_arm_reg;

  // Choose what the engine loads when it is waiting
  always_comb begin
    start_go    = 1'b0;
    start_pat   = 11'h7ff;
    start_len   = frame_len;
    take_buf    = 1'b0;
    wr_direct   = 1'b0;
    start_break = 1'b0;
    if (tx_state_reg == TX_WAIT && TX_ENABLE && te_prev_reg) begin
      if (preamble_reg) begin
        start_go = 1'b1;
      end else if (SEND_BREAK) begin
        start_go    = 1'b1;
        start_break = 1'b1;
        start_pat   = 11'h000;
      end else if (after_break_reg) begin
        start_go  = 1'b1;
        start_len = MARK_BITS;
      end else if (!TX_EMPTY_FLAG) begin
        start_go  = 1'b1;
        take_buf  = 1'b1;
        start_pat = {1'b1, WORD_LEN_SEL ? tx_buf8_reg : 1'b1,
                     tx_buffer_reg, 1'b0};
      end else if (DATA_WRITE) begin
        start_go  = 1'b1;
        wr_direct = 1'b1;
        start_pat = {1'b1, WORD_LEN_SEL ? TX_BIT8 : 1'b1,
                     DATA_WRITE_VALUE, 1'b0};
      end
    end
  end

  // Frame engine: shift out on the transmit tick
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tx_state_reg <= TX_WAIT;
      tx_shift_reg <= 11'h7ff;
      tx_bits_reg  <= 4'h0;
      tx_sub_reg   <= 4'h0;
    end else if (start_go) begin
      tx_state_reg <= TX_SHIFT;
      tx_shift_reg <= start_pat;
      tx_bits_reg  <= start_len;
      tx_sub_reg   <= 4'h0;
    end else if (tx_state_reg == TX_SHIFT && tick[0]) begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
      // Bit boundary: next bit, or frame over
      if (tx_sub_reg == TICK_LAST) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_bits_reg  <= tx_bits_reg - 4'h1;
        if (frame_end) begin
          tx_state_reg <= TX_WAIT;
        end
      end
    end
  end

  // Pin: frame bit while shifting, high otherwise
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      SERIAL_OUT_PIN <= 1'b1;
      SERIAL_OUT_EN  <= 1'b0;
    end else begin
      SERIAL_OUT_PIN <= (tx_state_reg == TX_SHIFT)
                      ? tx_shift_reg[0] : 1'b1;
      SERIAL_OUT_EN  <= TX_ENABLE;
    end
  end

  // Enable history: rising edge owes an idle frame
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      te_prev_reg     <= 1'b0;
      preamble_reg    <= 1'b0;
      after_break_reg <= 1'b0;
    end else begin
      te_prev_reg <= TX_ENABLE;
      if (TX_ENABLE && !te_prev_reg) begin
        preamble_reg <= 1'b1;
      end else if (start_go) begin
        preamble_reg <= 1'b0;
      end
      // Remember a break so the closing mark follows it
      if (start_go) begin
        after_break_reg <= start_break;
      end
    end
  end

  // Buffer holds the word written while the shifter is busy
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tx_buffer_reg <= BYTE_RST;
      tx_buf8_reg   <= 1'b0;
    end else if (DATA_WRITE && !wr_direct) begin
      tx_buffer_reg <= DATA_WRITE_VALUE;
      tx_buf8_reg   <= TX_BIT8;
    end
  end

  // Status read arms the clearing write
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tx_arm_reg <= 1'b0;
    end else if (STATUS_READ) begin
      tx_arm_reg <= 1'b1;
    end else if (DATA_WRITE) begin
      tx_arm_reg <= 1'b0;
    end
  end

  // Transmit flags; a set in the clearing cycle wins
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      TX_EMPTY_FLAG    <= TX_EMPTY_RST;
      TX_COMPLETE_FLAG <= TX_DONE_RST;
    end else begin
      if (take_buf || wr_direct || (!TX_ENABLE && te_prev_reg)) begin
        TX_EMPTY_FLAG <= 1'b1;
      end else if (tx_clear) begin
        TX_EMPTY_FLAG <= 1'b0;
      end
      if (frame_end) begin
        TX_COMPLETE_FLAG <= 1'b1;
      end else if (tx_clear) begin
        TX_COMPLETE_FLAG <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver line: three stages, change taken when last two agree

  logic             sync1_reg;         // Metastability catcher
  logic             sync2_reg;
  logic             sync3_reg;
  logic             line_reg;          // Filtered line level

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      line_reg  <= 1'b1;
    end else begin
      sync1_reg <= SERIAL_IN_PIN;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        line_reg <= sync3_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive engine

  ast_rx_state_type rx_state_reg;      // Off, hunting or in frame
  logic [3:0]       rx_sub_reg;        // Tick within bit
  logic [3:0]       rx_idx_reg;        // 0 start, then data, then stop
  logic [1:0]       samp_reg;          // First two centre samples
  logic [8:0]       rx_shift_reg;      // Data bits
  logic             rx_noise_reg;      // Disagreeing samples seen
  logic [7:0]       idle_cnt_reg;      // High ticks while hunting
  logic             done_reg;          // Character complete pulse
  logic             done_fe_reg;       // Its stop bit was low
  logic             idle_evt_reg;      // Idle frame seen pulse
  logic             maj;               // Majority bit value
  logic             disagree;          // Samples differ
  logic [3:0]       stop_idx;          // Index of stop bit
  logic [7:0]       idle_len;          // Idle frame in ticks

  assign maj      = (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & line_reg)
                  | (samp_reg[1] & line_reg);
  assign disagree = !((samp_reg[0] == samp_reg[1])
                  && (samp_reg[1] == line_reg));
  assign stop_idx = frame_len - 4'h1;
  assign idle_len = WORD_LEN_SEL ? IDLE_TICKS_9 : IDLE_TICKS_8;

  // Hunt, sample at ticks 7..9, decide at tick 9
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rx_state_reg <= RX_OFF;
      rx_sub_reg   <= 4'h0;
      rx_idx_reg   <= 4'h0;
      samp_reg     <= 2'h0;
      rx_shift_reg <= 9'h000;
      rx_noise_reg <= 1'b0;
      idle_cnt_reg <= 8'h00;
      done_reg     <= 1'b0;
      done_fe_reg  <= 1'b0;
      idle_evt_reg <= 1'b0;
    end else begin
      done_reg     <= 1'b0;
      idle_evt_reg <= 1'b0;
      if (!RX_ENABLE) begin
        rx_state_reg <= RX_OFF;
      end else if (rx_state_reg == RX_OFF) begin
        rx_state_reg <= RX_HUNT;
        idle_cnt_reg <= 8'h00;
      end else if (tick[1] && rx_state_reg == RX_HUNT) begin
        // Start edge, or count toward an idle frame
        if (!line_reg) begin
          rx_state_reg <= RX_FRAME;
          rx_sub_reg   <= 4'h0;
          rx_idx_reg   <= 4'h0;
          rx_noise_reg <= 1'b0;
          idle_cnt_reg <= 8'h00;
        end else if (idle_cnt_reg <= idle_len) begin
          idle_cnt_reg <= idle_cnt_reg + 8'h01;
          idle_evt_reg <= (idle_cnt_reg + 8'h01 == idle_len);
        end
      end else if (tick[1] && rx_state_reg == RX_FRAME) begin
        rx_sub_reg <= rx_sub_reg + 4'h1;
        if (rx_sub_reg == SAMPLE_FIRST) begin
          samp_reg[0] <= line_reg;
        end
        if (rx_sub_reg == SAMPLE_MID) begin
          samp_reg[1] <= line_reg;
        end
        if (rx_sub_reg == SAMPLE_LAST) begin
          rx_noise_reg <= rx_noise_reg | disagree;
          if (rx_idx_reg == 4'h0 && maj) begin
            rx_state_reg <= RX_HUNT;                     // False start
          end else if (rx_idx_reg == stop_idx) begin
            // Stop bit: character done; a low stop bit means break or lost sync
            done_reg     <= 1'b1;
            done_fe_reg  <= !maj;
            rx_state_reg <= RX_HUNT;
          end else if (rx_idx_reg != 4'h0) begin
            rx_shift_reg[rx_idx_reg - 4'h1] <= maj;
          end
        end
        if (rx_sub_reg == TICK_LAST) begin
          rx_idx_reg <= rx_idx_reg + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive flags, buffer and mute

  logic             rx_arm_reg;        // Status read seen
  logic             idle_arm_reg;      // Idle may be flagged again
  logic             word_msb;          // Address mark bit
  logic             accept;            // Character reaches software
  logic             rx_clear;          // Armed data read

  assign word_msb = WORD_LEN_SEL ? rx_shift_reg[8] : rx_shift_reg[7];
  assign accept   = done_reg && (!RX_MUTE_BIT
                  || (WAKE_METHOD && word_msb));
  assign rx_clear = DATA_READ && rx_arm_reg;

  // Status access arms the clearing read
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rx_arm_reg <= 1'b0;
    end else if (STATUS_READ) begin
      rx_arm_reg <= 1'b1;
    end else if (DATA_READ) begin
      rx_arm_reg <= 1'b0;
    end
  end

  // Flags: disable clears; new events win over the clearing read
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      RX_FULL_FLAG       <= 1'b0;
      IDLE_FLAG          <= 1'b0;
      OVERRUN_FLAG       <= 1'b0;
      NOISE_FLAG         <= 1'b0;
      FRAMING_ERROR_FLAG <= 1'b0;
      RX_DATA            <= BYTE_RST;
      RX_BIT8            <= 1'b0;
      idle_arm_reg       <= IDLE_ARM_RST;
    end else if (!RX_ENABLE) begin
      RX_FULL_FLAG       <= 1'b0;
      IDLE_FLAG          <= 1'b0;
      OVERRUN_FLAG       <= 1'b0;
      NOISE_FLAG         <= 1'b0;
      FRAMING_ERROR_FLAG <= 1'b0;
    end else begin
      if (rx_clear) begin
        RX_FULL_FLAG       <= 1'b0;
        IDLE_FLAG          <= 1'b0;
        OVERRUN_FLAG       <= 1'b0;
        NOISE_FLAG         <= 1'b0;
        FRAMING_ERROR_FLAG <= 1'b0;
      end
      if (accept && RX_FULL_FLAG && !rx_clear) begin
        OVERRUN_FLAG <= 1'b1;
      end else if (accept) begin
        // Move shifter to buffer with its error marks
        RX_DATA            <= rx_shift_reg[7:0];
        RX_BIT8            <= rx_shift_reg[8];
        RX_FULL_FLAG       <= 1'b1;
        NOISE_FLAG         <= rx_noise_reg;
        FRAMING_ERROR_FLAG <= done_fe_reg;
        idle_arm_reg       <= 1'b1;
      end
      // Idle once after reset and once per accepted character, never while muted
      if (idle_evt_reg && !RX_MUTE_BIT && idle_arm_reg) begin
        IDLE_FLAG    <= 1'b1;
        idle_arm_reg <= 1'b0;
      end
    end
  end

  // Mute: set by software, cleared by software or a wake-up
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      RX_MUTE_BIT <= 1'b0;
    end else if (RX_MUTE_SET) begin
      RX_MUTE_BIT <= 1'b1;
    end else if (RX_MUTE_CLEAR) begin
      RX_MUTE_BIT <= 1'b0;
    end else if (RX_MUTE_BIT && WAKE_METHOD && done_reg && word_msb) begin
      RX_MUTE_BIT <= 1'b0;
    end else if (RX_MUTE_BIT && !WAKE_METHOD && idle_evt_reg) begin
      RX_MUTE_BIT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request, gated by the global mask

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= !GLOBAL_IRQ_MASK
           && ((TX_EMPTY_IRQ_EN && TX_EMPTY_FLAG)
           ||  (TX_COMPLETE_IRQ_EN && TX_COMPLETE_FLAG)
           ||  (RX_IRQ_EN && (RX_FULL_FLAG || OVERRUN_FLAG))
           ||  (IDLE_IRQ_EN && IDLE_FLAG));
    end
  end

endmodule // ast_transceiver

// File: test/ast_transceiver_props.sv
// Purpose: Port assertions for the async serial transceiver
// Assumes: One core clock, asynchronous active-high reset
// Notes:   Bound into every transceiver instance
`timescale 1ns/100ps
module ast_props (
  // Clock, reset, strobes and levels
  input wire logic CORE_CLK, RESET, STATUS_READ, DATA_WRITE, DATA_READ,
  input wire logic RX_ENABLE, RX_IRQ_EN, GLOBAL_IRQ_MASK, SERIAL_OUT_PIN,
  // Flags and interrupt
  input wire logic TX_EMPTY_FLAG, TX_COMPLETE_FLAG, RX_FULL_FLAG, IDLE_FLAG,
  input wire logic OVERRUN_FLAG, NOISE_FLAG, FRAMING_ERROR_FLAG,
  input wire logic RX_MUTE_BIT, IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Clear pairs: access cycle, then data cycle
  sequence s_tx_pair; STATUS_READ ##1 DATA_WRITE; endsequence
  sequence s_rx_pair; STATUS_READ ##1 DATA_READ; endsequence
  a_reset_state: assert property (disable iff (1'h0)
    RESET |=> SERIAL_OUT_PIN && TX_EMPTY_FLAG && !RX_FULL_FLAG && !IRQ)
    else $error("bad state in reset");
  a_tx_clear: assert property (
    s_tx_pair |=> !TX_COMPLETE_FLAG) else $error("complete kept");
  a_rx_clear: assert property (
    s_rx_pair |=> !RX_FULL_FLAG) else $error("full kept");
  a_rx_off_clear: assert property (
    !RX_ENABLE [*2] |=> !(RX_FULL_FLAG || IDLE_FLAG || OVERRUN_FLAG ||
    NOISE_FLAG || FRAMING_ERROR_FLAG)) else $error("flags kept while off");
  a_mute_quiet: assert property (
    RX_MUTE_BIT |=> !$rose(IDLE_FLAG) && !$rose(OVERRUN_FLAG))
    else $error("flag set while muted");
  a_start_low: assert property (
    $fell(SERIAL_OUT_PIN) |=> !SERIAL_OUT_PIN [*8]) else $error("short start");
  a_fe_with_full: assert property (
    $rose(FRAMING_ERROR_FLAG) |-> RX_FULL_FLAG) else $error("lone error");
  a_irq_rx_on: assert property (
    RX_FULL_FLAG && RX_IRQ_EN && !GLOBAL_IRQ_MASK |=> IRQ)
    else $error("receive irq missing");
  a_irq_masked: assert property (
    GLOBAL_IRQ_MASK |=> !IRQ) else $error("irq not masked");
endmodule // ast_props

bind ast_transceiver ast_props u_props (.*);

// File: test/ast_serial_station.sv
// Purpose: Remote serial station driving and sampling the two lines
// Assumes: Bit length given in core cycles per call
// Notes:   Line rests at the mark level between frames
`timescale 1ns/100ps
module ast_serial_station (
  input  wire logic CORE_CLK,
  input  wire logic SERIAL_OUT_PIN,
  output logic      SERIAL_IN_PIN
);
  initial SERIAL_IN_PIN = 1'h1;
  // Send start, nb data bits LSB first, then the given stop level
  task automatic send(input logic [8:0] d, input int nb, bl,
                      input logic stop);
    @(negedge CORE_CLK) SERIAL_IN_PIN <= 1'h0;
    for (int i = 0; i <= nb; i++) begin
      repeat (bl) @(negedge CORE_CLK);
      SERIAL_IN_PIN <= (i == nb) ? stop : d[i];
    end
    repeat (bl) @(negedge CORE_CLK);
    SERIAL_IN_PIN <= 1'h1;
  endtask
  // Sample mid-bit; ok is the stop level, 0 on a missing frame
  task automatic recv(input int nb, bl, output logic [8:0] d,
                      output logic ok);
    d = 9'h000;
    ok = 1'h0;
    for (int k = 0; k < 4000 && SERIAL_OUT_PIN !== 1'h0; k++)
      @(negedge CORE_CLK);
    // No frame: hand back a word no 8-bit frame can give
    if (SERIAL_OUT_PIN !== 1'h0) begin
      d = 9'h1ff;
      return;
    end
    repeat (bl / 2) @(negedge CORE_CLK);
    for (int i = 0; i < nb; i++) begin
      repeat (bl) @(negedge CORE_CLK);
      d[i] = SERIAL_OUT_PIN;
    end
    repeat (bl) @(negedge CORE_CLK);
    ok = SERIAL_OUT_PIN;
  endtask
endmodule // ast_serial_station

// File: test/testbench.sv
// Purpose: Self-checking bench for the async serial transceiver
// Assumes: Extended rate of one cycle per tick unless changed
// Notes:   Inputs change on the falling edge only
`timescale 1ns/100ps
module testbench;
  import ast_pkg::*;
  logic CORE_CLK = 1'h0, RESET = 1'h1, STATUS_READ, DATA_WRITE, DATA_READ;
  logic WORD_LEN_SEL, TX_BIT8, WAKE_METHOD, TX_ENABLE, RX_ENABLE, SEND_BREAK;
  logic RX_MUTE_SET, RX_MUTE_CLEAR, TX_EMPTY_IRQ_EN, TX_COMPLETE_IRQ_EN;
  logic RX_IRQ_EN, IDLE_IRQ_EN, GLOBAL_IRQ_MASK, SERIAL_IN_PIN, RX_BIT8, IRQ;
  logic SERIAL_OUT_PIN, SERIAL_OUT_EN, TX_EMPTY_FLAG, TX_COMPLETE_FLAG;
  logic RX_FULL_FLAG, IDLE_FLAG, OVERRUN_FLAG, NOISE_FLAG, RX_MUTE_BIT;
  logic FRAMING_ERROR_FLAG, ok;
  logic [1:0] SHARED_PRESCALE;
  logic [2:0] TX_DIVIDE_FACTOR, RX_DIVIDE_FACTOR;
  logic [7:0] DATA_WRITE_VALUE, EXT_TX_PRESCALE, EXT_RX_PRESCALE, RX_DATA;
  logic [8:0] got, e;
  logic [9:0] r;
  // Rows: word length select, ninth bit, byte
  logic [9:0] rows [3] = '{10'h0a5, 10'h33c, 10'h2c3};
  int fails = 0, cmp_count = 0, cyc = 0, i;
  always #50 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) cyc <= cyc + 1;
  ast_transceiver dut (.*);
  ast_serial_station station (.*);
  task automatic check(input logic [15:0] s, x);
    cmp_count++;
    if (s !== x) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Status access, then data write (w=1) or data read (w=0)
  task automatic pair(input logic w, input logic [8:0] d);
    @(negedge CORE_CLK) STATUS_READ = 1'h1;
    @(negedge CORE_CLK) {STATUS_READ, DATA_WRITE, DATA_READ} = {1'h0, w, !w};
    {TX_BIT8, DATA_WRITE_VALUE} = d;
    @(negedge CORE_CLK) {DATA_WRITE, DATA_READ} = 2'h0;
  endtask
  // Bounded wait on receive full (s=0) or overrun (s=1)
  task automatic wait_hi(input logic s);
    for (int k = 0; k < 64; k++) begin
      @(negedge CORE_CLK);
      if ((s ? OVERRUN_FLAG : RX_FULL_FLAG) === 1'h1) return;
    end
    fails++;
    finish_test();
  endtask
  initial begin
    {STATUS_READ, DATA_WRITE, DATA_READ, WORD_LEN_SEL, TX_BIT8, WAKE_METHOD,
     TX_ENABLE, RX_ENABLE, SEND_BREAK, RX_MUTE_SET, RX_MUTE_CLEAR,
     TX_EMPTY_IRQ_EN, TX_COMPLETE_IRQ_EN, RX_IRQ_EN, IDLE_IRQ_EN,
     GLOBAL_IRQ_MASK, SHARED_PRESCALE, TX_DIVIDE_FACTOR, RX_DIVIDE_FACTOR,
     DATA_WRITE_VALUE} = '0;
    {EXT_TX_PRESCALE, EXT_RX_PRESCALE} = 16'h0101;
    repeat (12) @(negedge CORE_CLK);
    check({RX_DATA, TX_EMPTY_FLAG, TX_COMPLETE_FLAG, RX_FULL_FLAG,
           SERIAL_OUT_PIN, SERIAL_OUT_EN}, 16'h001a);
    {RESET, TX_ENABLE, RX_ENABLE} = 3'h3;
    i = cyc;
    pair(1'h1, 9'h05a);
    check({TX_EMPTY_FLAG, SERIAL_OUT_EN}, 2'h1);
    station.recv(8, TICKS_PER_BIT, got, ok);
    check({got, ok}, 16'h0b5);
    check(cyc - i >= IDLE_TICKS_8 + 152, 1'h1);
    check(IDLE_FLAG, 1'h1);
    for (i = 0; i < 3; i++) begin
      r = rows[i];
      e = {r[8] & r[9], r[7:0]};
      WORD_LEN_SEL = r[9];
      station.send(r[8:0], 8 + r[9], TICKS_PER_BIT, 1'h1);
      wait_hi(1'h0);
      check({RX_BIT8 & r[9], RX_DATA, FRAMING_ERROR_FLAG, NOISE_FLAG,
             TX_COMPLETE_FLAG}, {e, 3'h1});
      pair(1'h0, 9'h000);
      check(RX_FULL_FLAG, 1'h0);
      pair(1'h1, r[8:0]);
      check({TX_EMPTY_FLAG, TX_COMPLETE_FLAG}, 2'h2);
      station.recv(8 + r[9], TICKS_PER_BIT, got, ok);
      check({got, ok}, {e, 1'h1});
      $display("row %0d done", i);
    end
    WORD_LEN_SEL = 1'h0;
    station.send(9'h000, 8, TICKS_PER_BIT, 1'h0);
    wait_hi(1'h0);
    check({FRAMING_ERROR_FLAG, RX_DATA}, 9'h100);
    RX_IRQ_EN = 1'h1;
    repeat (2) @(negedge CORE_CLK);
    check(IRQ, 1'h1);
    {RX_IRQ_EN, TX_COMPLETE_IRQ_EN} = 2'h1;
    repeat (2) @(negedge CORE_CLK);
    check(IRQ, 1'h1);
    {GLOBAL_IRQ_MASK, RX_ENABLE} = 2'h2;
    repeat (3) @(negedge CORE_CLK);
    check({IRQ, RX_FULL_FLAG, FRAMING_ERROR_FLAG}, 3'h0);
    RX_ENABLE = 1'h1;
    station.send(9'h011, 8, TICKS_PER_BIT, 1'h1);
    station.send(9'h022, 8, TICKS_PER_BIT, 1'h1);
    wait_hi(1'h1);
    check({OVERRUN_FLAG, RX_DATA}, 9'h111);
    pair(1'h0, 9'h000);
    {WAKE_METHOD, RX_MUTE_SET} = 2'h3;
    @(negedge CORE_CLK) RX_MUTE_SET = 1'h0;
    station.send(9'h005, 8, TICKS_PER_BIT, 1'h1);
    repeat (40) @(negedge CORE_CLK);
    check({RX_MUTE_BIT, RX_FULL_FLAG, OVERRUN_FLAG}, 3'h4);
    station.send(9'h085, 8, TICKS_PER_BIT, 1'h1);
    wait_hi(1'h0);
    check({RX_MUTE_BIT, RX_DATA}, 9'h085);
    pair(1'h0, 9'h000);
    {WAKE_METHOD, RX_MUTE_SET} = 2'h1;
    @(negedge CORE_CLK) RX_MUTE_SET = 1'h0;
    repeat (200) @(negedge CORE_CLK);
    check({RX_MUTE_BIT, IDLE_FLAG}, 2'h0);
    RX_MUTE_SET = 1'h1;
    @(negedge CORE_CLK) {RX_MUTE_SET, RX_MUTE_CLEAR} = 2'h1;
    @(negedge CORE_CLK) RX_MUTE_CLEAR = 1'h0;
    check(RX_MUTE_BIT, 1'h0);
    SEND_BREAK = 1'h1;
    station.recv(8, TICKS_PER_BIT, got, ok);
    SEND_BREAK = 1'h0;
    check({got, ok}, 16'h000);
    for (int k = 0; k < 400 && SERIAL_OUT_PIN !== 1'h1; k++)
      @(negedge CORE_CLK);
    check(SERIAL_OUT_PIN, 1'h1);
    {TX_ENABLE, RX_ENABLE} = 2'h0;
    repeat (2) @(negedge CORE_CLK);
    {EXT_TX_PRESCALE, TX_DIVIDE_FACTOR} = 11'h001;
    TX_ENABLE = 1'h1;
    pair(1'h1, 9'h0c6);
    station.recv(8, 64, got, ok);
    check({got, ok}, 16'h18d);
    $display("edge cases done");
    finish_test();
  end
endmodule // testbench
